// File: hdl/wake_pkg.sv
// package: constants, modes and codes for the wake input detection block
package wake_pkg;

	// ==========================================================
	// clock and filter timing
	localparam int CLK_MHZ = 200;
	localparam int SHORT_FILTER_US = 16;
	localparam int LONG_FILTER_US = 64;
	localparam int SHORT_FILTER_CYC = SHORT_FILTER_US * CLK_MHZ;
	localparam int LONG_FILTER_CYC = LONG_FILTER_US * CLK_MHZ;
	localparam int FILT_CNT_W = 14;

	// ==========================================================
	// pin counts
	localparam int NUM_WAKE = 3;
	localparam int NUM_FAIL = 2;

	// ==========================================================
	// detection field codes
	localparam logic [1:0] DET_STATIC_SHORT = 2'h0;
	localparam logic [1:0] DET_STATIC_LONG = 2'h1;
	localparam logic [1:0] DET_CYCLIC_A = 2'h2;
	localparam logic [1:0] DET_CYCLIC_B = 2'h3;

	// ==========================================================
	// pull field codes
	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] PULL_UP = 2'h2;
	localparam logic [1:0] PULL_AUTO = 2'h3;

	// ==========================================================
	// chip modes, one-hot
	typedef enum logic [4:0] {
		CHIP_NORMAL = 5'h01,
		CHIP_STOP = 5'h02,
		CHIP_SLEEP = 5'h04,
		CHIP_FAILSAFE = 5'h08,
		CHIP_RESTART = 5'h10
	} chip_mode_type;

	// pins 1 and 2 are the ones gated by measurement mode
	localparam logic [NUM_WAKE-1:0] MEAS_PINS = 3'h3;

endpackage

// File: hdl/wake_filter.sv
// module: one edge filter with a programmable stable time
`timescale 1ns/10ps
module wake_filter
	import wake_pkg::*;
#(
	parameter int CNT_W = wake_pkg::FILT_CNT_W
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic sample_en,
	input wire logic pin_in,
	input wire logic [CNT_W-1:0] filt_len,
	output logic level_ff,
	output logic edge_ff
);

	logic cand_ff;
	logic [CNT_W-1:0] cnt_ff;

	// ==========================================================
	// filter: a crossing starts the timer, a crossing back discards it
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cand_ff <= 1'b0;
			cnt_ff <= '0;
			level_ff <= 1'b0;
			edge_ff <= 1'b0;
		end else begin
			edge_ff <= 1'b0;
			if (!sample_en) begin
				cnt_ff <= '0; // outside the window no partial timing survives
				cand_ff <= level_ff;
			end else if (pin_in == level_ff) begin
				cnt_ff <= '0; // crossed back: event discarded
				cand_ff <= level_ff;
			end else if (cand_ff != pin_in) begin
				cand_ff <= pin_in; // timer starts on a crossing
				cnt_ff <= '0;
			end else if (cnt_ff >= filt_len - CNT_W'(1)) begin
				level_ff <= pin_in;
				edge_ff <= 1'b1; // either direction is an event
				cnt_ff <= '0;
			end else begin
				cnt_ff <= cnt_ff + CNT_W'(1);
			end
		end
	end

endmodule

// File: hdl/wake_pull.sv
// module: pull source selection for one wake pin
`timescale 1ns/10ps
module wake_pull
	import wake_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [1:0] pull_sel,
	input wire logic gate,
	input wire logic level,
	output logic pull_up_ff,
	output logic pull_down_ff
);

	// ==========================================================
	// pull decode; auto mode follows the level input, which the top ties to the live pin
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pull_up_ff <= 1'b0;
			pull_down_ff <= 1'b0;
		end else if (gate) begin
			pull_up_ff <= 1'b0; // measurement turns pulls off
			pull_down_ff <= 1'b0;
		end else begin
			pull_up_ff <= (pull_sel == PULL_UP) || (pull_sel == PULL_AUTO && level);
			pull_down_ff <= (pull_sel == PULL_DOWN) || (pull_sel == PULL_AUTO && !level);
		end
	end

endmodule

// File: hdl/wake_input_detection.sv
// module: wake input detection top, three wake pins and two fail-output pins
`timescale 1ns/10ps
// Notes on behaviour
// - every wake pin reports both rising and falling crossings.
// - wake raises interrupt in normal or stop, wakes chip in sleep or fail-safe.
// - filter timer starts on crossing; crossing back before expiry discards event.
// - detect field picks static short, static long, cyclic timer a or b.
// - pull field picks none, pull-down, pull-up or automatic.
// - automatic mode pulls up on high level, down on low level.
// - per-pin enable bit blocks a pin as wake source.
// - wake from a pin sets its flag in status register a.
// - level bits show live level in normal/stop, sampled level in cyclic.
// - fail-output pins as wake inputs use short filter, report in status b.
// - cyclic pins are evaluated only during their timer on-window.
// - measurement off at reset; route switch closes only in normal mode.
// - measurement turns off pulls of pins 1-2 and freezes their bits.
// - pins 1-2 settings stay stored during measurement but are ignored.
// - measurement plus only pins 1-2 enabled and sleep command gives restart.
// - filter times come from the oscillator clock, short within 12 to 20 us.
module wake_input_detection
	import wake_pkg::*;
#(
	parameter int SHORT_CYC = wake_pkg::SHORT_FILTER_CYC,
	parameter int LONG_CYC = wake_pkg::LONG_FILTER_CYC
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [wake_pkg::NUM_WAKE-1:0] wake_pin,
	input wire logic [wake_pkg::NUM_FAIL-1:0] fail_pin,
	input wire logic [wake_pkg::NUM_FAIL-1:0] fail_as_wake,
	input wire wake_pkg::chip_mode_type chip_mode,
	input wire logic sleep_cmd,
	input wire logic [wake_pkg::NUM_WAKE-1:0] wake_enable_control,
	input wire logic [wake_pkg::NUM_WAKE-1:0] pull_select_hi,
	input wire logic [wake_pkg::NUM_WAKE-1:0] pull_select_lo,
	input wire logic [wake_pkg::NUM_WAKE-1:0] filter_select_hi,
	input wire logic [wake_pkg::NUM_WAKE-1:0] filter_select_lo,
	input wire logic measure_enable,
	input wire logic cyclic_timer_a_on,
	input wire logic cyclic_timer_b_on,
	input wire logic [wake_pkg::NUM_WAKE-1:0] status_a_clear,
	input wire logic [wake_pkg::NUM_FAIL-1:0] status_b_clear,
	output logic [wake_pkg::NUM_WAKE-1:0] wake_source_status_a,
	output logic [wake_pkg::NUM_FAIL-1:0] wake_source_status_b,
	output logic [wake_pkg::NUM_WAKE+wake_pkg::NUM_FAIL-1:0] pin_level_status,
	output logic [wake_pkg::NUM_WAKE-1:0] pull_up_en,
	output logic [wake_pkg::NUM_WAKE-1:0] pull_down_en,
	output logic measure_route_switch,
	output logic wake_irq,
	output logic wake_up_chip,
	output logic spi_fail_set,
	output logic restart_req
);
	import wake_pkg::*;

	localparam logic [FILT_CNT_W-1:0] SHORT_LEN = FILT_CNT_W'(SHORT_CYC);
	localparam logic [FILT_CNT_W-1:0] LONG_LEN = FILT_CNT_W'(LONG_CYC);

	logic [NUM_WAKE-1:0] wk_level;
	logic [NUM_WAKE-1:0] wk_edge;
	logic [NUM_WAKE-1:0] wk_sample;
	logic [NUM_WAKE-1:0] wk_gate;
	logic [NUM_WAKE-1:0] wk_cyclic;
	logic [NUM_FAIL-1:0] fo_level;
	logic [NUM_FAIL-1:0] fo_edge;
	logic [NUM_WAKE-1:0] wk_hit;
	logic [NUM_FAIL-1:0] fo_hit;
	logic normal_or_stop;
	logic sleepish;
	logic [NUM_WAKE-1:0] wake_status_ff;
	logic [NUM_FAIL-1:0] fail_status_ff;
	logic [NUM_WAKE+NUM_FAIL-1:0] level_ff;
	logic [NUM_WAKE-1:0] pu_ff;
	logic [NUM_WAKE-1:0] pd_ff;
	logic route_ff;
	logic irq_ff;
	logic wakeup_ff;
	logic spi_fail_ff;
	logic restart_ff;
	logic only_meas_src;

	assign normal_or_stop = (chip_mode == CHIP_NORMAL) || (chip_mode == CHIP_STOP);
	assign sleepish = (chip_mode == CHIP_SLEEP) || (chip_mode == CHIP_FAILSAFE);

	// ==========================================================
	// wake pins: gate, window and filter length per pin
	genvar gi;
	generate
		for (gi = 0; gi < NUM_WAKE; gi++) begin : g_wk
			logic [1:0] det;
			logic [FILT_CNT_W-1:0] flen;
			assign det = {filter_select_hi[gi], filter_select_lo[gi]};
			assign wk_gate[gi] = measure_enable && MEAS_PINS[gi]; // settings ignored, still stored
			assign wk_cyclic[gi] = (det == DET_CYCLIC_A) || (det == DET_CYCLIC_B);
			// cyclic pins only look during the assigned timer on-time
			assign wk_sample[gi] = !wk_gate[gi] && ((det == DET_CYCLIC_A) ? cyclic_timer_a_on :
				(det == DET_CYCLIC_B) ? cyclic_timer_b_on : 1'b1);
			assign flen = (det == DET_STATIC_LONG) ? LONG_LEN : SHORT_LEN;

			wake_filter #(
				.CNT_W(FILT_CNT_W)
			) u_filt (
				.mclk(mclk),
				.rst_b(rst_b),
				.sample_en(wk_sample[gi]),
				.pin_in(wake_pin[gi]),
				.filt_len(flen),
				.level_ff(wk_level[gi]),
				.edge_ff(wk_edge[gi])
			);

			wake_pull u_pull (
				.mclk(mclk),
				.rst_b(rst_b),
				.pull_sel({pull_select_hi[gi], pull_select_lo[gi]}),
				.gate(wk_gate[gi]),
				.level(wake_pin[gi]),
				.pull_up_ff(pu_ff[gi]),
				.pull_down_ff(pd_ff[gi])
			);
		end

		// fail-output pins reuse the filter with the fixed short static time
		for (gi = 0; gi < NUM_FAIL; gi++) begin : g_fo
			wake_filter #(
				.CNT_W(FILT_CNT_W)
			) u_filt (
				.mclk(mclk),
				.rst_b(rst_b),
				.sample_en(fail_as_wake[gi]),
				.pin_in(fail_pin[gi]),
				.filt_len(SHORT_LEN),
				.level_ff(fo_level[gi]),
				.edge_ff(fo_edge[gi])
			);
		end
	endgenerate

	assign wk_hit = wk_edge & wake_enable_control & ~wk_gate;
	assign fo_hit = fo_edge & fail_as_wake;

	// ==========================================================
	// sticky wake flags; a new event beats a clear in the same cycle
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wake_status_ff <= '0;
		end else begin
			wake_status_ff <= (wake_status_ff & ~status_a_clear) | wk_hit;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fail_status_ff <= '0;
		end else begin
			fail_status_ff <= (fail_status_ff & ~status_b_clear) | fo_hit;
		end
	end

	// ==========================================================
	// level bits: live in normal/stop, held otherwise and for gated pins
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			level_ff <= '0;
		end else if (normal_or_stop) begin
			for (int i = 0; i < NUM_WAKE; i++) begin
				if (!wk_gate[i]) begin
					// cyclic pins show the filter's last sampled level
					level_ff[i] <= wk_cyclic[i] ? wk_level[i] : wake_pin[i];
				end
			end
			level_ff[NUM_WAKE +: NUM_FAIL] <= fail_pin;
		end
	end

	// ==========================================================
	// measurement route switch, only in normal mode
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			route_ff <= 1'b0;
		end else begin
			route_ff <= measure_enable && (chip_mode == CHIP_NORMAL);
		end
	end

	// ==========================================================
	// wake signalling: interrupt request or chip wake pulse
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq_ff <= 1'b0;
			wakeup_ff <= 1'b0;
		end else begin
			irq_ff <= normal_or_stop && (|wk_hit || |fo_hit);
			wakeup_ff <= sleepish && (|wk_hit || |fo_hit);
		end
	end

	// sleep refused when measurement leaves no real wake source
	assign only_meas_src = |(wake_enable_control & MEAS_PINS) && !(|(wake_enable_control & ~MEAS_PINS))
		&& !(|fail_as_wake);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			spi_fail_ff <= 1'b0;
			restart_ff <= 1'b0;
		end else begin
			spi_fail_ff <= sleep_cmd && measure_enable && only_meas_src;
			restart_ff <= sleep_cmd && measure_enable && only_meas_src;
		end
	end

	assign wake_source_status_a = wake_status_ff;
	assign wake_source_status_b = fail_status_ff;
	assign pin_level_status = level_ff;
	assign pull_up_en = pu_ff;
	assign pull_down_en = pd_ff;
	assign measure_route_switch = route_ff;
	assign wake_irq = irq_ff;
	assign wake_up_chip = wakeup_ff;
	assign spi_fail_set = spi_fail_ff;
	assign restart_req = restart_ff;

endmodule

// File: testbench/wake_input_detection_sva.sv
// checker: port-level properties of the wake input detection block
`timescale 1ns/10ps
module wake_input_detection_chk
	import wake_pkg::*;
#(
	parameter int SHORT_CYC = 8,
	parameter int LONG_CYC = 32
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [2:0] wake_pin,
	input wire logic [1:0] fail_as_wake,
	input wire wake_pkg::chip_mode_type chip_mode,
	input wire logic sleep_cmd,
	input wire logic [2:0] wake_enable_control,
	input wire logic [2:0] pull_select_hi,
	input wire logic [2:0] pull_select_lo,
	input wire logic [2:0] filter_select_hi,
	input wire logic measure_enable,
	input wire logic [2:0] status_a_clear,
	input wire logic [2:0] wake_source_status_a,
	input wire logic [1:0] wake_source_status_b,
	input wire logic [4:0] pin_level_status,
	input wire logic [2:0] pull_up_en,
	input wire logic [2:0] pull_down_en,
	input wire logic measure_route_switch,
	input wire logic wake_irq,
	input wire logic wake_up_chip,
	input wire logic spi_fail_set,
	input wire logic restart_req
);
	// ==========================================================
	// properties, all on the one clock domain
	default clocking dcb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	property p_switch;
		$past(rst_b) |-> measure_route_switch == $past(measure_enable && chip_mode == CHIP_NORMAL);
	endproperty
	a_switch: assert property (p_switch) else $error("route switch state wrong");
	property p_irq_mode;
		wake_irq |-> ($past(chip_mode) == CHIP_NORMAL || $past(chip_mode) == CHIP_STOP);
	endproperty
	a_irq_mode: assert property (p_irq_mode) else $error("interrupt outside normal or stop");
	property p_wake_mode;
		wake_up_chip |-> ($past(chip_mode) == CHIP_SLEEP || $past(chip_mode) == CHIP_FAILSAFE);
	endproperty
	a_wake_mode: assert property (p_wake_mode) else $error("chip wake outside sleep or fail-safe");
	property p_irq_flag;
		(wake_irq || wake_up_chip) |-> (|wake_source_status_a || |wake_source_status_b);
	endproperty
	a_irq_flag: assert property (p_irq_flag) else $error("wake event without a source flag");
	property p_sleep_refuse;
		sleep_cmd && measure_enable && fail_as_wake == 2'h0 && !wake_enable_control[2] && |wake_enable_control[1:0]
			|=> spi_fail_set && restart_req;
	endproperty
	a_sleep_refuse: assert property (p_sleep_refuse) else $error("sleep not refused");
	property p_pull_gate;
		$past(rst_b) && $past(measure_enable) |-> (pull_up_en[1:0] == 2'h0 && pull_down_en[1:0] == 2'h0);
	endproperty
	a_pull_gate: assert property (p_pull_gate) else $error("pull active on measured pins");
	property p_pull_auto;
		$past(rst_b) && $past(pull_select_hi[2] && pull_select_lo[2])
			|-> pull_up_en[2] == $past(wake_pin[2]) && pull_down_en[2] == !$past(wake_pin[2]);
	endproperty
	a_pull_auto: assert property (p_pull_auto) else $error("automatic pull does not follow pin");
	property p_pull_down;
		$past(rst_b) && $past(!pull_select_hi[2] && pull_select_lo[2]) |-> pull_down_en[2] && !pull_up_en[2];
	endproperty
	a_pull_down: assert property (p_pull_down) else $error("pull-down code gives wrong sources");
	property p_level;
		$past(rst_b) && $past(chip_mode == CHIP_NORMAL && !filter_select_hi[2])
			|-> pin_level_status[2] == $past(wake_pin[2]);
	endproperty
	a_level: assert property (p_level) else $error("level bit does not track pin");
	property p_sticky;
		wake_source_status_a[2] && !status_a_clear[2] |=> wake_source_status_a[2];
	endproperty
	a_sticky: assert property (p_sticky) else $error("wake flag dropped without clear");
	property p_enable;
		$rose(wake_source_status_a[2]) |-> $past(wake_enable_control[2]);
	endproperty
	a_enable: assert property (p_enable) else $error("flag set on disabled pin");
	c_irq: cover property (wake_irq);
	c_wake: cover property (wake_up_chip);
	c_fail: cover property (spi_fail_set);
endmodule
bind wake_input_detection wake_input_detection_chk #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) chk (.*);

// File: testbench/wake_switch_model.sv
// partner: switch contacts on the wake pins, a floating node when open
`timescale 1ns/10ps
module wake_switch_model (
	input wire logic mclk,
	input wire logic [2:0] closed,
	input wire logic [2:0] level,
	input wire logic [2:0] pull_up_en,
	input wire logic [2:0] pull_down_en,
	output logic [2:0] wake_pin
);
	logic [2:0] float_ff = 3'h0;
	// an open contact without a current source wanders, so it toggles off the sampling edge
	always @(negedge mclk) begin
		float_ff <= ~float_ff;
	end
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			wake_pin[i] = closed[i] ? level[i] : (pull_up_en[i] ? 1'b1 : (pull_down_en[i] ? 1'b0 : float_ff[i]));
		end
	end
endmodule

// File: testbench/wake_input_detection_tb.sv
// testbench: stimulus, reference model and comparisons for wake detection
`timescale 1ns/10ps
module wake_input_detection_tb;
	import wake_pkg::*;
	localparam int SC = 8;
	localparam int LC = 32;
	logic mclk = 0, rst_b = 0, meas = 0, sleep = 0, ta = 0, tb = 0, sw, irq, wup, sfail, rreq;
	logic [4:0] drv = 5'h00, lvl, flags;
	logic [2:0] wake_pin, en = 3'h0, phi = 3'h0, plo = 3'h0, fhi = 3'h0, flo = 3'h0, clr_a = 3'h0, st_a, pu, pd;
	logic [2:0] closed = 3'h7;
	logic [1:0] faw = 2'h0, clr_b = 2'h0, st_b;
	chip_mode_type mode = CHIP_NORMAL;
	int num_errors = 0, n_checks = 0, seed = 10511, n_irq = 0, n_wup = 0, n_sf = 0, c;
	assign flags = {st_b, st_a};
	always #2.5 mclk = ~mclk;
	wake_switch_model far (.mclk(mclk), .closed(closed), .level(drv[2:0]), .pull_up_en(pu), .pull_down_en(pd),
		.wake_pin(wake_pin));
	wake_input_detection #(.SHORT_CYC(SC), .LONG_CYC(LC)) uut (.mclk(mclk), .rst_b(rst_b), .wake_pin(wake_pin),
		.fail_pin(drv[4:3]), .fail_as_wake(faw), .chip_mode(mode), .sleep_cmd(sleep), .wake_enable_control(en),
		.pull_select_hi(phi), .pull_select_lo(plo), .filter_select_hi(fhi), .filter_select_lo(flo),
		.measure_enable(meas), .cyclic_timer_a_on(ta), .cyclic_timer_b_on(tb), .status_a_clear(clr_a),
		.status_b_clear(clr_b), .wake_source_status_a(st_a), .wake_source_status_b(st_b), .pin_level_status(lvl),
		.pull_up_en(pu), .pull_down_en(pd), .measure_route_switch(sw), .wake_irq(irq), .wake_up_chip(wup),
		.spi_fail_set(sfail), .restart_req(rreq));
	// pulse outputs last one cycle, so they are counted on every rising edge
	always @(posedge mclk) begin
		if (irq === 1'b1) n_irq++;
		if (wup === 1'b1) n_wup++;
		if (sfail === 1'b1 && rreq === 1'b1) n_sf++;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// reference: a change held longer than its filter is accepted if the pin may wake; the
	// pin is flipped back after hold cycles, and the wait is fixed because a discard shows nothing
	task automatic ev(input int idx, input int hold, input int n, input bit live, input string what);
		int k, lat;
		bit exp, ns;
		exp = live && (hold > n);
		ns = (mode == CHIP_NORMAL || mode == CHIP_STOP);
		lat = -1;
		clr_a = 3'h7;
		clr_b = 2'h3;
		wait_n(1);
		clr_a = 3'h0;
		clr_b = 2'h0;
		n_irq = 0;
		n_wup = 0;
		drv[idx] = ~drv[idx];
		for (k = 0; k < 4 * n + 20; k++) begin
			@(negedge mclk);
			if (k + 1 == hold) drv[idx] = ~drv[idx];
			if (lat < 0 && flags[idx] === 1'b1) lat = k;
		end
		check(what, flags[idx], exp);
		check("irq", n_irq, exp && ns);
		check("chip wake", n_wup, exp && !ns);
		if (exp) check("latency", lat >= n && lat <= n + 3, 1);
		if (ns && !(meas && idx < 2)) check("level", lvl[idx], drv[idx]);
		$display("test %s pin %0d done", what, idx);
	endtask
	initial begin
		wait_n(12);
		rst_b = 1;
		wait_n(1);
		check("reset", {flags, lvl, pu, pd, sw, irq, wup, sfail, rreq}, 0);
		en = 3'h7;
		for (c = 0; c < 3; c++) begin
			ev(c, 999, SC, 1, "rise");
			ev(c, 999, SC, 1, "fall");
			ev(c, 1 + $unsigned($random(seed)) % (SC - 2), SC, 1, "bounce");
		end
		flo = 3'h2;
		ev(1, SC + 4, LC, 1, "long bounce");
		ev(1, 999, LC, 1, "long");
		flo = 3'h0;
		for (c = 2; c < 4; c++) begin
			fhi[0] = 1'b1;
			flo[0] = c[0];
			ta = (c == 3);
			ev(0, 2 * SC + 4, SC, 0, "window shut");
			ta = (c == 2); // now only the timer matching the detect code is on: a for code 2, b for code 3
			tb = (c == 3);
			ev(0, 999, SC, 1, "window open");
			ta = 0;
			tb = 0;
		end
		fhi = 3'h0;
		flo = 3'h0;
		en = 3'h3;
		ev(2, 999, SC, 0, "disabled");
		en = 3'h7;
		faw = 2'h3;
		ev(3, 999, SC, 1, "fail pin");
		ev(4, SC - 2, SC, 1, "fail bounce");
		faw = 2'h0;
		mode = CHIP_SLEEP;
		ev(2, 999, SC, 1, "sleep wake");
		mode = CHIP_FAILSAFE;
		ev(2, 999, SC, 1, "fail-safe wake");
		mode = CHIP_STOP;
		ev(2, 999, SC, 1, "stop wake");
		mode = CHIP_NORMAL;
		meas = 1;
		phi = 3'h7;
		wait_n(3);
		check("switch", sw, 1);
		check("pulls", {pu, pd}, 6'h20);
		ev(0, 999, SC, 0, "gated");
		ev(1, 999, SC, 0, "gated");
		mode = CHIP_STOP;
		wait_n(2);
		check("switch", sw, 0);
		mode = CHIP_NORMAL;
		for (c = 0; c < 2; c++) begin
			en = c ? 3'h7 : 3'h3;
			n_sf = 0;
			sleep = 1;
			wait_n(1);
			sleep = 0;
			wait_n(3);
			check("refusal", n_sf, c == 0);
		end
		meas = 0;
		plo = 3'h4;
		wait_n(3);
		check("stored pulls", pu[1:0], 2'h3);
		closed = 3'h3;
		wait_n(10);
		check("auto pull", {pu[2], pd[2], lvl[2]}, {drv[2], ~drv[2], drv[2]});
		closed = 3'h7;
		drv[2] = 1'b1;
		wait_n(3);
		closed = 3'h3;
		wait_n(10);
		check("auto pull high", {pu[2], pd[2], lvl[2]}, 3'h5);
		closed = 3'h7;
		close_out();
	end
endmodule
